// ==== dv/bidirectional_reset_supervisor_bench.sv ====
/*
  bench joining supervisor and host over the shared line.
  assumes small hold-off counts; the bench plays the third device.
*/
`timescale 1ns/10ps
`default_nettype none
module bidirectional_reset_supervisor_bench import brs_pkg::*;;
  // ****************************************
  // instances, scoreboard and scenarios
  // ****************************************
  localparam int HOLD = 300;
  logic CLOCK, RESET, SUPPLY_LOW, SUPPLY_DEAD, PUSH_BUTTON_IN_N, SELF_RESET;
  logic RESET_ASSERTED, EDGE_FLAG, IN_RESET, BOOT_ALT, BOOT_NORMAL;
  int n_mismatch, cmp_count, cycles;
  logic [1:0] exp_q[$];
  brs_link_if link();
  brs_supervisor #(.HOLD_3_CYC(HOLD)) brs_supervisor_inst (.CLOCK(CLOCK),
    .RESET(RESET), .SUPPLY_LOW(SUPPLY_LOW), .SUPPLY_DEAD(SUPPLY_DEAD),
    .PUSH_BUTTON_IN_N(PUSH_BUTTON_IN_N), .LINK(link.supervisor),
    .RESET_ASSERTED(RESET_ASSERTED), .EDGE_FLAG(EDGE_FLAG));
  brs_host brs_host_inst (.CLOCK(CLOCK), .RESET(RESET), .SELF_RESET(SELF_RESET),
    .LINK(link.host), .IN_RESET(IN_RESET), .BOOT_ALT(BOOT_ALT), .BOOT_NORMAL(BOOT_NORMAL));
  brs_monitor #(.HOLD_CYC(HOLD)) brs_monitor_inst (.CLOCK(CLOCK), .RESET(RESET),
    .sup_pull_low(link.sup_pull_low), .sup_active_up(link.sup_active_up),
    .sup_passive_up(link.sup_passive_up), .sup_floating(link.sup_floating),
    .host_pull_low(link.host_pull_low), .other_pull_low(link.other_pull_low),
    .line_level(link.line_level));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task idle(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  // bounded wait for release; the count must cover the hold-off
  task wait_free(input int min);
    int n;
    n = 0;
    while (RESET_ASSERTED !== 1'b0 && n < 3000) begin
      @(negedge CLOCK);
      n++;
    end
    // a hang or an overlong hold-off must fail too, not only a short one
    check("hold-off", n >= min && n <= min + 40, 1);
    idle(100);
  endtask
  initial begin
    CLOCK = 0;
    forever #2 CLOCK = ~CLOCK;
  end
  // boot pulses sampled at the falling edge, where they have settled
  always @(negedge CLOCK) begin
    cycles++;
    if (cycles > 60000) begin
      n_mismatch++;
      conclude();
    end
    if (BOOT_ALT === 1'b1 || BOOT_NORMAL === 1'b1) begin
      if (exp_q.size() == 0) check("boot", {BOOT_ALT, BOOT_NORMAL}, 0);
      else check("boot", {BOOT_ALT, BOOT_NORMAL}, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'hf73d));
    {RESET, SUPPLY_LOW, SUPPLY_DEAD, SELF_RESET, link.other_pull_low} = 5'h10;
    PUSH_BUTTON_IN_N = 1;
    idle(5);
    RESET = 0;
    exp_q.push_back(2'b01);
    wait_free(HOLD);
    // short dip and short bounce must both be ignored
    SUPPLY_LOW = 1;
    idle(10);
    SUPPLY_LOW = 0;
    PUSH_BUTTON_IN_N = 0;
    idle(10);
    PUSH_BUTTON_IN_N = 1;
    idle(60);
    check("glitch", RESET_ASSERTED, 0);
    // brownout, then a second dip inside the hold-off restarts it
    exp_q.push_back(2'b01);
    SUPPLY_LOW = 1;
    idle(60);
    check("brownout", RESET_ASSERTED, 1);
    SUPPLY_LOW = 0;
    idle(100 + $urandom_range(0, 150));
    SUPPLY_LOW = 1;
    idle(60);
    SUPPLY_LOW = 0;
    wait_free(HOLD);
    exp_q.push_back(2'b01);
    PUSH_BUTTON_IN_N = 0;
    idle(260 + $urandom_range(0, 100));
    check("button", RESET_ASSERTED, 1);
    PUSH_BUTTON_IN_N = 1;
    wait_free(HOLD);
    check("in reset", IN_RESET, 0);
    // third device holds the line past the flag setup time
    exp_q.push_back(2'b01);
    link.other_pull_low = 1;
    idle(120 + $urandom_range(0, 60));
    check("edge flag", EDGE_FLAG, 1);
    check("sup idle", RESET_ASSERTED, 0);
    link.other_pull_low = 0;
    idle(100);
    check("flag used", EDGE_FLAG, 0);
    repeat (3) begin
      exp_q.push_back(2'b10);
      SELF_RESET = 1;
      idle(1);
      SELF_RESET = 0;
      idle(60 + $urandom_range(0, 40));
    end
    exp_q.push_back(2'b01);
    SUPPLY_LOW = 1;
    SUPPLY_DEAD = 1;
    idle(60);
    check("float", link.sup_pull_low, 0);
    SUPPLY_DEAD = 0;
    idle(60);
    check("recover", RESET_ASSERTED, 1);
    SUPPLY_LOW = 0;
    wait_free(HOLD);
    check("boots left", exp_q.size(), 0);
    conclude();
  end
endmodule
`default_nettype wire

// ==== dv/brs_monitor.sv ====
/*
  checker for the shared reset line between supervisor and host.
  assumes the bench hands it the interface signals and the hold-off count.
*/
`timescale 1ns/10ps
`default_nettype none
module brs_monitor #(
  parameter int HOLD_CYC = 300
) (
  input wire logic CLOCK, // timebase
  input wire logic RESET, // sync, active high
  input wire logic sup_pull_low, // supervisor sink
  input wire logic sup_active_up, // active pull-up
  input wire logic sup_passive_up, // resistor connected
  input wire logic sup_floating, // output open
  input wire logic host_pull_low, // host sink
  input wire logic other_pull_low, // third device sink
  input wire logic line_level // resolved line
);
  // ****************************************
  // run lengths and properties
  // ****************************************
  int low_cnt;
  int up_cnt;
  int host_cnt;
  int sup_cnt;
  // run lengths of each level; a run of 100k cycles cannot wrap an int
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      low_cnt <= 0;
      up_cnt <= 0;
      host_cnt <= 0;
      sup_cnt <= 0;
    end else begin
      low_cnt <= line_level ? 0 : low_cnt + 1;
      up_cnt <= sup_active_up ? up_cnt + 1 : 0;
      host_cnt <= host_pull_low ? host_cnt + 1 : 0;
      sup_cnt <= sup_pull_low ? sup_cnt + 1 : 0;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  AST_PASSIVE_OFF: assert property (sup_pull_low |-> !sup_passive_up)
    else $error("resistor connected while asserting");
  AST_WIRED_AND: assert property ((sup_pull_low || host_pull_low || other_pull_low) |-> !line_level)
    else $error("line high while pulled low");
  // only long lows count: shorter ones need not arm the edge flag
  AST_SHOT_FIRE: assert property (($rose(line_level) && low_cnt >= 100 && !sup_pull_low) |-> ##[0:12] sup_active_up)
    else $error("no pull-up shot after release");
  AST_SHOT_MAX: assert property (up_cnt <= 500)
    else $error("active pull-up on too long");
  AST_NO_UP_LOW: assert property (sup_pull_low |-> !sup_active_up)
    else $error("active pull-up while asserting");
  AST_FLOAT: assert property (sup_floating |-> !(sup_pull_low || sup_active_up || sup_passive_up))
    else $error("output driven while floating");
  AST_HOST_LEN: assert property ($fell(host_pull_low) |-> host_cnt == 32)
    else $error("host pulse length wrong");
  AST_HOLD: assert property (($fell(sup_pull_low) && !sup_floating) |-> sup_cnt >= HOLD_CYC)
    else $error("reset released before hold-off");
  cover property ($rose(sup_active_up));
  cover property ($fell(host_pull_low));
  cover property ($rose(sup_floating));
endmodule
`default_nettype wire

// ==== rtl/brs_defines.svh ====
/*
  constants for the bidirectional reset supervisor and its processor end.
  assumes a 250 MHz clock (4 ns period) for every timing count.
*/
// Summary of operation
// - drive line low while supply below trip
// - hold reset full hold-off after supply recovers
// - supply dip clears timer, asserts reset immediately
// - hold-off chosen at build: 1/20/140/1120 ms
// - push-button low asserts, then hold-off after release
// - push-button debounced internally, open reads inactive
// - push-button driver holds low at least 1 us
// - line is wired-AND, anyone may pull low
// - line low sets transition-edge flag
// - external pull-down lasts at least 400 ns
// - flag plus line high fires pull-up one-shot
// - one-shot expiry disables active pull-up
// - pull-up sequence runs on every release
// - passive pull-up disconnected while device asserts
// - processor drives low four cycles, waits two, samples
// - still low means external reset, normal vector
// - already high means self reset, alternate vector
// - released line must rise within 500 ns
// - short supply glitches below threshold ignored
// - supply below 1 V makes output float
`ifndef BRS_DEFINES_SVH
`define BRS_DEFINES_SVH

// ****************************************
// timing figures and derived cycle counts
// ****************************************
`define BRS_CLK_NS 4
`define BRS_HOLD_OFF_1_MS 1
`define BRS_HOLD_OFF_2_MS 20
`define BRS_HOLD_OFF_3_MS 140
`define BRS_HOLD_OFF_4_MS 1120
`define BRS_MS_CYCLES(ms) (((ms) * 1000000) / `BRS_CLK_NS)
`define BRS_ONE_SHOT_NS 2000
`define BRS_ONE_SHOT_CYC (`BRS_ONE_SHOT_NS / `BRS_CLK_NS)
`define BRS_BUTTON_MIN_NS 1000
`define BRS_BUTTON_CYC (`BRS_BUTTON_MIN_NS / `BRS_CLK_NS)
`define BRS_GLITCH_NS 100
`define BRS_GLITCH_CYC (`BRS_GLITCH_NS / `BRS_CLK_NS)
`define BRS_EDGE_SETUP_NS 400
`define BRS_EDGE_SETUP_CYC (`BRS_EDGE_SETUP_NS / `BRS_CLK_NS)
`define BRS_HOST_PHASE_CYC 8
`define BRS_HOST_DRIVE_PHASES 4
`define BRS_HOST_WAIT_PHASES 2
// synchroniser idle levels {line, button, dead, supply}: line low,
// button released, supply alive but below trip, as at power-on
`define BRS_PIN_RESET 4'h5

`endif

// ==== rtl/brs_host.sv ====
/*
  processor end: pulses the shared line on its own resets, then samples
  it to tell self-caused from external resets.
  assumes the supervisor provides pull-up on the shared line.
*/
`timescale 1ns/10ps
`default_nettype none
`include "brs_defines.svh"
module brs_host
  import brs_pkg::*;
#(
  parameter int PHASE_CYC = `BRS_HOST_PHASE_CYC
) (
  input wire logic CLOCK, // 250 MHz clock
  input wire logic RESET, // synchronous, active high
  input wire logic SELF_RESET, // pulse: internal fault reset
  brs_link_if.host LINK, // shared reset line
  output logic IN_RESET, // processor held in reset
  output logic BOOT_ALT, // pulse: self-caused, alternate vector
  output logic BOOT_NORMAL // pulse: external, normal vector
);
  typedef struct packed {
    brs_host_state_e st;
    logic [2:0] sync;
    logic level;
    logic [15:0] cnt;
    logic pull;
    logic alt;
    logic norm;
    logic in_reset; // registered copy of the state decode
  } brs_host_s;
  brs_host_s r, next_r;

  // ****************************************
  // sequence
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.sync = {r.sync[1:0], LINK.line_level};
    if (r.sync[1] == r.sync[2]) begin
      next_r.level = r.sync[2];
    end
    next_r.alt = 1'b0;
    next_r.norm = 1'b0;
    next_r.cnt = r.cnt + 16'h0001;
    case (r.st)
      BRS_H_RUN: begin
        if (SELF_RESET || !r.level) begin
          next_r.st = BRS_H_DRIVE;
          next_r.pull = 1'b1;
          next_r.cnt = '0;
        end
      end
      BRS_H_DRIVE: begin
        // drive low about four phases, then release
        if (r.cnt >= 16'(PHASE_CYC * `BRS_HOST_DRIVE_PHASES - 1)) begin
          next_r.st = BRS_H_WAIT;
          next_r.pull = 1'b0;
          next_r.cnt = '0;
        end
      end
      BRS_H_WAIT: begin
        if (r.cnt >= 16'(PHASE_CYC * `BRS_HOST_WAIT_PHASES - 1)) begin
          if (r.level) begin
            next_r.st = BRS_H_RUN;
            next_r.alt = 1'b1;
          end else begin
            next_r.st = BRS_H_EXT;
          end
        end
      end
      BRS_H_EXT: begin
        if (r.level) begin
          next_r.st = BRS_H_RUN;
          next_r.norm = 1'b1;
        end
      end
      default: begin
        next_r.st = BRS_H_RUN;
      end
    endcase
    // decoded ahead so the output leaves a flop
    next_r.in_reset = (next_r.st != BRS_H_RUN);
  end

  // power-on treated as an external reset
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      r <= '0;
      r.st <= BRS_H_EXT;
      r.in_reset <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign LINK.host_pull_low = r.pull;
  assign IN_RESET = r.in_reset;
  assign BOOT_ALT = r.alt;
  assign BOOT_NORMAL = r.norm;
endmodule
`default_nettype wire

// ==== rtl/brs_link_if.sv ====
/*
  shared reset line between supervisor and processor.
  assumes a testbench drives other_pull_low; the level is resolved here: wired-AND plus pull-ups.
*/
`timescale 1ns/10ps
`default_nettype none
interface brs_link_if;
  logic sup_pull_low; // supervisor sinks the line
  logic sup_active_up; // supervisor active pull-up on
  logic sup_passive_up; // supervisor resistor connected
  logic sup_floating; // supervisor output open (supply below 1 V)
  logic host_pull_low; // processor sinks the line
  logic other_pull_low; // any third device sinks the line
  logic line_level; // resolved line level, high = released
  // wired-AND: any sink wins, otherwise high when some pull-up is present
  assign line_level = !(sup_pull_low | host_pull_low | other_pull_low)
    && (sup_passive_up | sup_active_up);
  modport supervisor (
    output sup_pull_low, sup_active_up, sup_passive_up, sup_floating,
    input line_level
  );
  modport host (
    output host_pull_low,
    input line_level
  );
endinterface
`default_nettype wire

// ==== rtl/brs_pkg.sv ====
/*
  types shared by both ends of the reset supervisor link.
  assumes brs_defines.svh for the numbers.
*/
package brs_pkg;
  typedef enum logic [1:0] {
    BRS_HOLD_1MS,
    BRS_HOLD_20MS,
    BRS_HOLD_140MS,
    BRS_HOLD_1120MS
  } brs_hold_sel_e;
  typedef enum logic [2:0] {
    BRS_H_RUN,
    BRS_H_DRIVE,
    BRS_H_WAIT,
    BRS_H_EXT,
    BRS_H_BOOT
  } brs_host_state_e;
endpackage

// ==== rtl/brs_supervisor.sv ====
/*
  supervisor end: supply monitor, push-button debounce, hold-off timer,
  transition-edge flag and active pull-up one-shot.
  assumes comparator results arrive as asynchronous levels on pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "brs_defines.svh"
module brs_supervisor
  import brs_pkg::*;
#(
  parameter brs_hold_sel_e HOLD_SEL = BRS_HOLD_140MS,
  parameter int HOLD_1_CYC = `BRS_MS_CYCLES(`BRS_HOLD_OFF_1_MS),
  parameter int HOLD_2_CYC = `BRS_MS_CYCLES(`BRS_HOLD_OFF_2_MS),
  parameter int HOLD_3_CYC = `BRS_MS_CYCLES(`BRS_HOLD_OFF_3_MS),
  parameter int HOLD_4_CYC = `BRS_MS_CYCLES(`BRS_HOLD_OFF_4_MS),
  parameter int GLITCH_CYC = `BRS_GLITCH_CYC,
  parameter int BUTTON_CYC = `BRS_GLITCH_CYC
) (
  input wire logic CLOCK, // 250 MHz timebase
  input wire logic RESET, // synchronous, active high
  input wire logic SUPPLY_LOW, // comparator: supply below trip
  input wire logic SUPPLY_DEAD, // comparator: supply below 1 V
  input wire logic PUSH_BUTTON_IN_N, // push-button, low asserts
  brs_link_if.supervisor LINK, // shared reset line
  output logic RESET_ASSERTED, // supervisor asserting reset; line held low unless supply dead
  output logic EDGE_FLAG // transition-edge flag state
);
  localparam int CW = 32;
  localparam logic [CW-1:0] HOLD_CYC =
    (HOLD_SEL == BRS_HOLD_1MS) ? CW'(HOLD_1_CYC) :
    (HOLD_SEL == BRS_HOLD_20MS) ? CW'(HOLD_2_CYC) :
    (HOLD_SEL == BRS_HOLD_140MS) ? CW'(HOLD_3_CYC) : CW'(HOLD_4_CYC);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic supply_ok; // filtered supply state
    logic [15:0] glitch_cnt;
    logic btn_low; // debounced push-button
    logic [15:0] btn_cnt;
    logic [CW-1:0] hold_cnt;
    logic asserting;
    logic dead;
    logic edge_flag;
    logic [15:0] shot_cnt;
    logic active_up;
    logic pull_out; // registered line sink
    logic passive_out; // registered resistor switch
    logic active_out; // registered active pull-up
    logic float_out; // registered open state
  } brs_sup_s;
  brs_sup_s r, next_r;

  logic sup_raw, dead_raw, btn_raw, line_raw, btn_n_raw;
  logic [3:0] pin_lvl;

  // ****************************************
  // input synchronisers
  // ****************************************
  // comparators and pins each cross through three flops
  brs_pin_sync #(
    .WIDTH(4),
    .INIT(`BRS_PIN_RESET)
  ) brs_pin_sync_inst (
    .CLOCK(CLOCK), // timebase
    .RESET(RESET), // synchronous reset
    .pin({LINK.line_level, PUSH_BUTTON_IN_N, SUPPLY_DEAD, SUPPLY_LOW}), // raw levels
    .level(pin_lvl) // agreed levels
  );

  // unpack the agreed levels; the button pin is active low
  assign {line_raw, btn_n_raw, dead_raw, sup_raw} = pin_lvl;
  assign btn_raw = !btn_n_raw;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.dead = dead_raw;
    // a dip must last past the glitch window before it counts
    if (sup_raw && r.supply_ok) begin
      if (r.glitch_cnt >= 16'(GLITCH_CYC - 1)) begin
        next_r.supply_ok = 1'b0;
        next_r.glitch_cnt = '0;
      end else begin
        next_r.glitch_cnt = r.glitch_cnt + 16'h0001;
      end
    end else begin
      next_r.glitch_cnt = '0;
      next_r.supply_ok = !sup_raw;
    end
    // button must hold its new level before it is believed
    if (btn_raw != r.btn_low) begin
      if (r.btn_cnt >= 16'(BUTTON_CYC - 1)) begin
        next_r.btn_low = btn_raw;
        next_r.btn_cnt = '0;
      end else begin
        next_r.btn_cnt = r.btn_cnt + 16'h0001;
      end
    end else begin
      next_r.btn_cnt = '0;
    end
    // hold-off: restart from zero on any cause, count out once clear
    if (!next_r.supply_ok || next_r.btn_low) begin
      next_r.hold_cnt = '0;
      next_r.asserting = 1'b1;
    end else if (r.asserting) begin
      if (r.hold_cnt >= HOLD_CYC - 1) begin
        next_r.asserting = 1'b0;
      end else begin
        next_r.hold_cnt = r.hold_cnt + 1'b1;
      end
    end
    // the flag arms on any low, from whichever source
    if (!line_raw) begin
      next_r.edge_flag = 1'b1;
      next_r.active_up = 1'b0;
      next_r.shot_cnt = '0;
    end else if (r.edge_flag && !next_r.asserting) begin
      next_r.edge_flag = 1'b0;
      next_r.active_up = 1'b1;
      next_r.shot_cnt = '0;
    end else if (r.active_up) begin
      if (r.shot_cnt >= 16'(`BRS_ONE_SHOT_CYC - 1)) begin
        next_r.active_up = 1'b0;
      end else begin
        next_r.shot_cnt = r.shot_cnt + 16'h0001;
      end
    end
    // never fight our own pull-down with the active pull-up
    if (next_r.asserting) begin
      next_r.active_up = 1'b0;
      next_r.shot_cnt = '0;
    end
    // line drive leaves flops directly; everything opens when dead
    next_r.pull_out = next_r.asserting && !next_r.dead;
    next_r.passive_out = !next_r.asserting && !next_r.dead;
    next_r.active_out = next_r.active_up && !next_r.dead;
    next_r.float_out = next_r.dead;
  end

  // ****************************************
  // registers
  // ****************************************
  // reset state assumes supply low: line held until first hold-off ends
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      r <= '0;
      r.asserting <= 1'b1;
      r.pull_out <= 1'b1;
      r.edge_flag <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // line drive straight from flops
  assign LINK.sup_pull_low = r.pull_out;
  assign LINK.sup_passive_up = r.passive_out;
  assign LINK.sup_active_up = r.active_out;
  assign LINK.sup_floating = r.float_out;
  assign RESET_ASSERTED = r.asserting;
  assign EDGE_FLAG = r.edge_flag;
endmodule

// ****************************************
// pin synchroniser
// ****************************************
// a bit's agreed level moves only when stages two and three match,
// so one metastable sample never reaches the logic; costs a cycle
module brs_pin_sync
  import brs_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic CLOCK, // timebase
  input wire logic RESET, // synchronous, active high
  input wire logic [WIDTH-1:0] pin, // asynchronous levels
  output logic [WIDTH-1:0] level // agreed levels
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
    logic [WIDTH-1:0] third;
    logic [WIDTH-1:0] agreed;
  } brs_sync_s;
  brs_sync_s r, next_r;
  logic [WIDTH-1:0] same;

  // shift, then follow only where the last two stages match
  always_comb begin
    next_r = r;
    same = ~(r.second ^ r.third);
    next_r.first = pin;
    next_r.second = r.first;
    next_r.third = r.second;
    next_r.agreed = (same & r.third) | (~same & r.agreed);
  end

  // reset to each pin's idle level so no false edge follows reset
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      r.first <= INIT;
      r.second <= INIT;
      r.third <= INIT;
      r.agreed <= INIT;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.agreed;
endmodule
`default_nettype wire
